// ---- rtl/bsfc_core.sv ----
// buck controller core: sequencing, faults, pwm gate commands, register slave
module bsfc_core
    import bsfc_pkg::*;
#(
    parameter int SOFTSTART_CYCLES = SS_CYCLES,
    parameter int HICCUP_WAIT = HICCUP_CYCLES,
    parameter int LDO_OFF_WAIT = LDO_OFF_CYCLES
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire bsfc_cmp_s cmp_i,
    input wire bsfc_avs_req_s avs_req_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic high_gate_command_o,
    output logic low_gate_command_o,
    output logic rail_enable_o,
    output logic power_ok_output_o,
    output logic power_ok_output_oe_o
);

    typedef struct packed {
        bsfc_cmp_s sync1;
        bsfc_cmp_s sync2;
        logic sync_prev;
        bsfc_state_e fsm;
        logic [31:0] tmr;
        logic restart;
        logic ctrl_skip;
        logic [15:0] period;
        logic [15:0] max_on;
        logic [15:0] osc_cnt;
        logic [16:0] sync_age;
        logic sync_active;
        logic hs_want;
        logic cl_hold;
        logic cl_seen;
        logic zc_off;
        logic [15:0] on_cnt;
        logic [3:0] on_through;
        logic dropout;
        logic [7:0] refresh_cnt;
        logic [4:0] cl_cnt;
        logic ov_hold;
        logic fpwm;
        logic hs;
        logic ls;
        logic ldo_on;
        logic pok;
        logic pok_drv;
        logic wait_n;
        logic [31:0] rdata;
    } bsfc_core_s;

    bsfc_core_s q;
    bsfc_core_s d;
    logic [1:0] rst_sync_q;
    logic rst_n;

    // fixed 5V mode regulates on the output sense path
    function automatic bsfc_sense_s pick_sense(input bsfc_cmp_s c);
        pick_sense = c.fixed5v ? c.osense : c.fb;
    endfunction

    function automatic logic [31:0] merge_be(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
        merge_be = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                merge_be[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
    endfunction

    function automatic logic active_state(input bsfc_state_e s);
        active_state = (s == ST_SOFT) || (s == ST_RUN);
    endfunction

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    always_comb begin
        bsfc_cmp_s c;
        bsfc_sense_s s;
        logic sync_edge;
        logic cyc_start;
        logic mid;
        logic skip;
        logic hs_cmd;
        logic ls_cmd;
        logic [31:0] wr;
        logic [31:0] stat;
        d = q;
        d.sync1 = cmp_i;
        d.sync2 = q.sync1;
        d.sync_prev = q.sync2.sync_pin;
        c = q.sync2;
        s = pick_sense(q.sync2);

        // oscillator: a sync edge restarts the period
        sync_edge = c.sync_pin && !q.sync_prev;
        cyc_start = sync_edge || (q.osc_cnt >= q.period - 16'h0001);
        mid = (q.osc_cnt == {1'b0, q.period[15:1]});
        if (cyc_start) begin
            d.osc_cnt = 16'h0000;
        end else begin
            d.osc_cnt = q.osc_cnt + 16'h0001;
        end
        // without edges for two periods, the internal rate takes over
        if (sync_edge) begin
            d.sync_age = 17'h00000;
            d.sync_active = 1'b1;
        end else if (q.sync_age >= {q.period, 1'b0}) begin
            d.sync_active = 1'b0;
        end else begin
            d.sync_age = q.sync_age + 17'h00001;
        end
        d.fpwm = !q.ctrl_skip && (c.sync_pin || q.sync_active)
                 && (q.fsm == ST_RUN);

        // sequencing
        d.ldo_on = 1'b1;
        case (q.fsm)
            ST_SHUT: begin
                d.ldo_on = 1'b0;
                d.restart = 1'b0;
                if (c.enable) begin
                    d.fsm = ST_WAIT_RAIL;
                end
            end
            ST_WAIT_RAIL: begin
                if (c.rail_ok) begin
                    d.fsm = ST_WAIT_DECAY;
                end
            end
            ST_WAIT_DECAY: begin
                d.tmr = 32'h0;
                if (c.out_low_1v25) begin
                    d.fsm = ST_SOFT;
                end
            end
            ST_SOFT: begin
                d.tmr = q.tmr + 32'h1;
                if (q.tmr >= 32'(SOFTSTART_CYCLES - 1)) begin
                    d.fsm = ST_RUN;
                    d.restart = 1'b0;
                end
            end
            ST_RUN: begin
                if (s.low20) begin
                    d.fsm = ST_HICCUP;
                    d.tmr = 32'h0;
                end
            end
            ST_HICCUP: begin
                d.restart = 1'b1;
                d.tmr = q.tmr + 32'h1;
                if (q.tmr >= 32'(HICCUP_WAIT - 1)) begin
                    d.fsm = ST_WAIT_DECAY;
                end
            end
            ST_THERMAL: begin
                if (c.cooled && c.out_low_1v25) begin
                    d.fsm = ST_SOFT;
                    d.tmr = 32'h0;
                end
            end
            ST_LDO_OFF: begin
                d.ldo_on = 1'b0;
                d.tmr = q.tmr + 32'h1;
                if (q.tmr >= 32'(LDO_OFF_WAIT - 1)) begin
                    d.fsm = ST_WAIT_RAIL;
                end
            end
            default: begin
                d.fsm = ST_SHUT;
            end
        endcase

        // fault overrides, later ones take precedence
        if (active_state(q.fsm)) begin
            if (q.cl_cnt >= CL_RESTART_COUNT
                || (q.fsm == ST_SOFT && q.restart && c.cur_lim)) begin
                d.fsm = ST_HICCUP;
                d.tmr = 32'h0;
            end
        end
        if (q.fsm != ST_SHUT && q.fsm != ST_LDO_OFF) begin
            if (c.over_temp && q.fsm != ST_THERMAL) begin
                d.fsm = ST_THERMAL;
            end
            if (!c.rail_ok && q.fsm != ST_WAIT_RAIL) begin
                d.fsm = ST_WAIT_RAIL;
            end
            if (c.rail_droop) begin
                d.fsm = ST_LDO_OFF;
                d.tmr = 32'h0;
            end
        end
        if (!c.enable) begin
            d.fsm = ST_SHUT;
        end

        // cycle-level pwm
        if (!active_state(q.fsm)) begin
            d.hs_want = 1'b0;
            d.cl_hold = 1'b0;
            d.cl_seen = 1'b0;
            d.zc_off = 1'b0;
            d.on_through = 4'h0;
            d.dropout = 1'b0;
            d.refresh_cnt = 8'h00;
            d.cl_cnt = 5'h00;
            d.ov_hold = 1'b0;
        end else begin
            if (cyc_start) begin
                // still on at the boundary means a full cycle on
                if (q.hs_want) begin
                    if (q.on_through < DROP_COUNT) begin
                        d.on_through = q.on_through + 4'h1;
                    end
                    if (q.on_through >= DROP_COUNT - 4'h1) begin
                        d.dropout = 1'b1;
                    end
                end else begin
                    d.on_through = 4'h0;
                    d.dropout = 1'b0;
                end
                if (q.cl_seen && !s.above70) begin
                    d.cl_cnt = q.cl_cnt + 5'h01;
                end else begin
                    d.cl_cnt = 5'h00;
                end
                d.hs_want = !q.ov_hold;
                d.on_cnt = 16'h0000;
                d.cl_hold = 1'b0;
                d.cl_seen = 1'b0;
                d.zc_off = 1'b0;
            end else if (q.hs_want) begin
                d.on_cnt = q.on_cnt + 16'h0001;
                if (c.cur_lim) begin
                    d.hs_want = 1'b0;
                    d.cl_hold = 1'b1;
                    d.cl_seen = 1'b1;
                end else if (c.pwm_trip
                             || q.on_cnt >= q.max_on - 16'h0001) begin
                    d.hs_want = 1'b0;
                end
            end
            // refresh pulse at mid-period while in dropout
            if (q.dropout && mid) begin
                d.refresh_cnt = REFRESH_CYCLES;
            end else if (q.refresh_cnt != 8'h00) begin
                d.refresh_cnt = q.refresh_cnt - 8'h01;
            end
            if (!q.hs_want && c.zero_cross) begin
                d.zc_off = 1'b1;
            end
            if (s.ov113) begin
                d.ov_hold = 1'b1;
                d.hs_want = 1'b0;
            end else if (q.ov_hold && !s.uv90 && !s.ov111) begin
                d.ov_hold = 1'b0;
            end
        end

        // skip during soft-start, forced mode only once running
        skip = !q.fpwm;
        hs_cmd = q.hs_want && (q.refresh_cnt == 8'h00) && !q.ov_hold;
        ls_cmd = active_state(q.fsm) && !hs_cmd
                 && (q.ov_hold || q.refresh_cnt != 8'h00 || q.cl_hold
                     || !skip || !q.zc_off);
        // turning off is immediate; turning on waits for the other side
        d.hs = hs_cmd && !q.ls && c.ls_off_sense;
        d.ls = ls_cmd && !q.hs && c.hs_off_sense;
        if (!active_state(q.fsm) || !c.rail_ok || c.rail_droop) begin
            d.hs = 1'b0;
            d.ls = 1'b0;
        end

        d.pok = (q.fsm == ST_RUN) && !s.uv90 && !s.ov111;
        d.pok_drv = 1'b0;

        // register slave: one wait cycle, then the access completes
        stat = 32'h0;
        stat[STAT_STATE_LSB +: 4] = q.fsm;
        stat[STAT_DROP_BIT] = q.dropout;
        stat[STAT_SYNC_BIT] = q.sync_active;
        stat[STAT_FPWM_BIT] = q.fpwm;
        stat[STAT_RESTART_BIT] = q.restart;
        stat[STAT_POK_BIT] = q.pok;
        stat[STAT_PIN_BIT] = c.pok_pin;
        d.wait_n = 1'b0;
        if ((avs_req_i.read || avs_req_i.write) && !q.wait_n) begin
            d.wait_n = 1'b1;
            case (avs_req_i.address)
                REG_CTRL_OFS: d.rdata = {31'h0, q.ctrl_skip};
                REG_PERIOD_OFS: d.rdata = {16'h0, q.period};
                REG_MAXON_OFS: d.rdata = {16'h0, q.max_on};
                REG_STATUS_OFS: d.rdata = stat;
                default: d.rdata = 32'h0;
            endcase
        end
        if (avs_req_i.write && q.wait_n) begin
            case (avs_req_i.address)
                REG_CTRL_OFS: begin
                    wr = merge_be({31'h0, q.ctrl_skip},
                                  avs_req_i.writedata,
                                  avs_req_i.byteenable);
                    d.ctrl_skip = wr[CTRL_SKIP_BIT];
                end
                REG_PERIOD_OFS: begin
                    wr = merge_be({16'h0, q.period}, avs_req_i.writedata,
                                  avs_req_i.byteenable);
                    d.period = wr[15:0];
                end
                REG_MAXON_OFS: begin
                    wr = merge_be({16'h0, q.max_on}, avs_req_i.writedata,
                                  avs_req_i.byteenable);
                    d.max_on = wr[15:0];
                end
                default: wr = 32'h0;
            endcase
        end else begin
            wr = 32'h0;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.fsm <= ST_SHUT;
            q.ctrl_skip <= CTRL_RST;
            q.period <= PERIOD_RST;
            q.max_on <= MAX_ON_RST;
        end else begin
            q <= d;
        end
    end

    assign avs_readdata_o = q.rdata;
    assign avs_waitrequest_o = !q.wait_n;
    assign high_gate_command_o = q.hs;
    assign low_gate_command_o = q.ls;
    assign rail_enable_o = q.ldo_on;
    assign power_ok_output_o = q.pok_drv;
    // open drain: drive low whenever power is not good
    assign power_ok_output_oe_o = !q.pok;

endmodule

// ---- rtl/bsfc_pkg.sv ----
// constants, types and bus map of the buck switching and fault control core
// Operation
// - eight consecutive cycles with high side held on declare dropout
// - in dropout, force a low-side refresh pulse at switching clock rise; the core fires it at mid-period
// - enable turns rail on; above lockout, start with 5ms soft-start
// - power-ok released only once regulation is reached after start-up
// - enable low: regulator off, both gate commands off
// - after shutdown, wait until output below 1.25V, then soft-start
// - rail drooping to 2.9V: regulator off, both switches off
// - each rising edge on sync input restarts the switching period
// - when sync edges stop, fall back to the internal oscillator
// - sync low: skip; high or clocked: skip in soft-start, then forced
// - limit each cycle; below 0.7V, 16 consecutive limits force restart
// - overcurrent during restart repeats the restart until clear
// - output at 20% of target: stop switching, restart
// - overvoltage 13%: high side off, low side on until back in range
// - rail below lockout: both gates off until it recovers
// - power-ok low in standby, below 90% or above 111%
// - fixed 5V mode takes regulation and power-ok from output sense
// - over 175C stop; resume after 15C cooling and output below 1.25V
// - high side on at each period start; ends on trip, max duty, limit
// - after a current-limit end, low side stays on until next cycle
// - forced mode ignores zero crossing; low side is high side's inverse
// - skip mode turns low side off on zero inductor current
// - neither side turns on until the other is confirmed off
package bsfc_pkg;

    localparam int CLK_MHZ = 200;
    localparam int SS_TIME_MS = 5;
    localparam int SS_CYCLES = SS_TIME_MS * 1000 * CLK_MHZ;
    localparam int HICCUP_CYCLES = 2000;
    localparam int LDO_OFF_CYCLES = 2000;
    localparam logic [3:0] DROP_COUNT = 4'h8;
    localparam logic [4:0] CL_RESTART_COUNT = 5'h10;
    localparam logic [7:0] REFRESH_CYCLES = 8'h14;

    // default period stands for the resistor-set rate, about 468 kHz
    localparam logic [15:0] PERIOD_RST = 16'h01AB;
    localparam logic [15:0] MAX_ON_RST = 16'h01AB;
    localparam logic CTRL_RST = 1'b0;

    localparam logic [3:0] REG_CTRL_OFS = 4'h0;
    localparam logic [3:0] REG_PERIOD_OFS = 4'h4;
    localparam logic [3:0] REG_MAXON_OFS = 4'h8;
    localparam logic [3:0] REG_STATUS_OFS = 4'hC;

    localparam int CTRL_SKIP_BIT = 0;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_DROP_BIT = 4;
    localparam int STAT_SYNC_BIT = 5;
    localparam int STAT_FPWM_BIT = 6;
    localparam int STAT_RESTART_BIT = 7;
    localparam int STAT_POK_BIT = 8;
    localparam int STAT_PIN_BIT = 9;

    typedef enum logic [3:0] {
        ST_SHUT,
        ST_WAIT_RAIL,
        ST_WAIT_DECAY,
        ST_SOFT,
        ST_RUN,
        ST_HICCUP,
        ST_THERMAL,
        ST_LDO_OFF
    } bsfc_state_e;

    // output-level comparators, one set per sense path
    typedef struct packed {
        logic above70;
        logic uv90;
        logic ov111;
        logic ov113;
        logic low20;
    } bsfc_sense_s;

    typedef struct packed {
        logic enable;
        logic sync_pin;
        logic fixed5v;
        logic rail_ok;
        logic rail_droop;
        logic out_low_1v25;
        bsfc_sense_s fb;
        bsfc_sense_s osense;
        logic pwm_trip;
        logic cur_lim;
        logic zero_cross;
        logic over_temp;
        logic cooled;
        logic hs_off_sense;
        logic ls_off_sense;
        logic pok_pin;
    } bsfc_cmp_s;

    typedef struct packed {
        logic read;
        logic write;
        logic [3:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } bsfc_avs_req_s;

endpackage

// ---- sim/bsfc_core_checker.sv ----
// assertion checker for the buck switching and fault control core
module bsfc_core_checker
    import bsfc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire bsfc_cmp_s cmp_i,
    input wire bsfc_avs_req_s avs_req_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic high_gate_command_o,
    input wire logic low_gate_command_o,
    input wire logic rail_enable_o,
    input wire logic power_ok_output_o,
    input wire logic power_ok_output_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    wire hi = high_gate_command_o;
    wire lo = low_gate_command_o;
    wire pok_oe = power_ok_output_oe_o;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!reset_n_i);

    // inputs cross two flops and a register before a gate can move
    sequence en_low_s;
        (!cmp_i.enable) [*4];
    endsequence
    sequence rail_bad_s;
        (!cmp_i.rail_ok || cmp_i.rail_droop) [*4];
    endsequence
    sequence fb_low_s;
        (!cmp_i.fixed5v && cmp_i.fb.uv90) [*6];
    endsequence
    sequence os_low_s;
        (cmp_i.fixed5v && cmp_i.osense.uv90) [*6];
    endsequence

    gates_apart_a: assert property (!(hi && lo))
        else $error("both gate commands on");
    high_gap_a: assert property ($rose(hi) |-> $past(!lo))
        else $error("high side rose straight after low side");
    low_gap_a: assert property ($rose(lo) |-> $past(!hi))
        else $error("low side rose straight after high side");
    shut_gates_a: assert property (en_low_s |=> !hi && !lo)
        else $error("gates on while disabled");
    shut_rail_a: assert property
        (en_low_s ##1 (!cmp_i.enable) [*2] |=> !rail_enable_o)
        else $error("regulator on while disabled");
    lockout_a: assert property (rail_bad_s |=> !hi && !lo)
        else $error("gates on with rail low");
    pok_standby_a: assert property (en_low_s ##1 1'b1 |=> pok_oe)
        else $error("power ok released in standby");
    pok_fb_a: assert property (fb_low_s |=> pok_oe)
        else $error("power ok released with output low");
    pok_sense_a: assert property (os_low_s |=> pok_oe)
        else $error("power ok ignores output sense");
    pok_drive_a: assert property (pok_oe |-> !power_ok_output_o)
        else $error("power ok pin driven high");
    ov_high_a: assert property
        ((!cmp_i.fixed5v && cmp_i.fb.ov113) [*4] |=> !hi)
        else $error("high side on in overvoltage");
    limit_high_a: assert property (cmp_i.cur_lim [*4] |=> !hi)
        else $error("high side on past current limit");
    bus_ack_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for two cycles");
endmodule

bind bsfc_core bsfc_core_checker i_chk (.mclk_i(mclk_i),
    .reset_n_i(reset_n_i), .cmp_i(cmp_i), .avs_req_i(avs_req_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .high_gate_command_o(high_gate_command_o),
    .low_gate_command_o(low_gate_command_o), .rail_enable_o(rail_enable_o),
    .power_ok_output_o(power_ok_output_o),
    .power_ok_output_oe_o(power_ok_output_oe_o));

// ---- sim/bsfc_bridge_model.sv ----
// half-bridge and current sense model facing the gate commands
module bsfc_bridge_model (
    input wire logic mclk_i,
    input wire logic high_i,
    input wire logic low_i,
    input wire logic [15:0] lim_len_i,
    input wire logic [15:0] trip_len_i,
    output logic hs_off_o,
    output logic ls_off_o,
    output logic cur_lim_o,
    output logic pwm_trip_o,
    output logic zero_cross_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] amps_q = 16'h0;
    logic hs_off_q = 1'b1;
    logic ls_off_q = 1'b1;

    // a gate takes a cycle to discharge, so off is confirmed late
    always_ff @(posedge mclk_i) begin
        hs_off_q <= !high_i;
        ls_off_q <= !low_i;
        // saturates short of all ones so a limit of all ones never trips
        if (high_i && amps_q < 16'hFFFE)
            amps_q <= amps_q + 16'h1;
        else if (!high_i && low_i && amps_q != 16'h0)
            amps_q <= amps_q - 16'h1;
    end

    assign hs_off_o = hs_off_q;
    assign ls_off_o = ls_off_q;
    assign cur_lim_o = amps_q >= lim_len_i;
    assign pwm_trip_o = amps_q >= trip_len_i;
    assign zero_cross_o = low_i && amps_q == 16'h0;
endmodule

// ---- sim/tb_top.sv ----
// self-checking bench for the buck switching and fault control core
module tb_top
    import bsfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [31:0] e;
        logic [31:0] m;
    } bsfc_note_s;
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    bsfc_cmp_s cmp_tb = '0;
    bsfc_cmp_s cmp;
    bsfc_avs_req_s req = '0;
    logic chk_rd = 1'b0;
    logic [15:0] lim_len = 16'hFFFF;
    logic [15:0] trip_len = 16'h0064;
    logic [31:0] rdata, q, rv;
    logic wreq, hi, lo, rail_en, pok, pok_oe, hs_off, ls_off, lim, trip, zc;
    bsfc_note_s notes[$];
    bsfc_note_s nt;
    int n_errors = 0;
    int checked = 0;
    int seed = 32'h5809;
    int cnt;

    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end

    always_comb begin
        cmp = cmp_tb;
        cmp.hs_off_sense = hs_off;
        cmp.ls_off_sense = ls_off;
        cmp.cur_lim = lim;
        cmp.pwm_trip = trip;
        cmp.zero_cross = zc;
        // pulled-up pin reads high unless the core pulls it down
        cmp.pok_pin = !pok_oe;
    end

    bsfc_core #(.SOFTSTART_CYCLES(200), .HICCUP_WAIT(20), .LDO_OFF_WAIT(20))
        i_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .cmp_i(cmp),
        .avs_req_i(req), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
        .high_gate_command_o(hi), .low_gate_command_o(lo),
        .rail_enable_o(rail_en), .power_ok_output_o(pok),
        .power_ok_output_oe_o(pok_oe));

    bsfc_bridge_model i_model (.mclk_i(mclk_i), .high_i(hi), .low_i(lo),
        .lim_len_i(lim_len), .trip_len_i(trip_len), .hs_off_o(hs_off),
        .ls_off_o(ls_off), .cur_lim_o(lim), .pwm_trip_o(trip),
        .zero_cross_o(zc));

    task automatic close_out();
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic give_up();
        n_errors++;
        $display("wait ran out at t=%0t", $time);
        close_out();
    endtask

    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d, input logic [3:0] be,
                       input logic chk, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge mclk_i);
        req <= '{!wr, wr, a, d, be};
        chk_rd <= chk;
        // hold until waitrequest is sampled low; read data is taken there
        do begin
            @(posedge mclk_i);
            n++;
        end while (wreq !== 1'b0 && n < 100);
        r = rdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
        chk_rd <= 1'b0;
        if (n >= 100) give_up();
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF, 1'b0, q);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e,
                          input logic [31:0] m);
        notes.push_back('{e, m});
        bus(1'b0, a, 32'h0, 4'h0, 1'b1, q);
    endtask

    task automatic st(input bsfc_state_e s);
        rd_chk(REG_STATUS_OFS, {28'h0, s}, 32'hF);
    endtask

    task automatic bit_chk(input int b, input logic v);
        rd_chk(REG_STATUS_OFS, 32'(v) << b, 32'h1 << b);
    endtask

    task automatic poll(input bsfc_state_e s);
        int n;
        logic [31:0] v;
        n = 0;
        do begin
            bus(1'b0, REG_STATUS_OFS, 32'h0, 4'h0, 1'b0, v);
            n++;
        end while (v[3:0] !== s && n < 5000);
        if (n >= 5000) give_up();
        st(s);
    endtask

    task automatic settle();
        repeat (8) @(posedge mclk_i);
    endtask

    always @(posedge mclk_i) begin
        if (chk_rd && req.read && wreq === 1'b0) begin
            nt = notes.pop_front();
            check(nt.e, rdata & nt.m);
        end
    end

    initial begin
        repeat (5) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        rd_chk(REG_CTRL_OFS, 32'h0, 32'hFFFFFFFF);
        rd_chk(REG_PERIOD_OFS, {16'h0, PERIOD_RST}, 32'hFFFFFFFF);
        rd_chk(REG_MAXON_OFS, {16'h0, MAX_ON_RST}, 32'hFFFFFFFF);
        rv = $random(seed);
        bus(1'b1, REG_MAXON_OFS, rv, 4'h1, 1'b0, q);
        rd_chk(REG_MAXON_OFS, {16'h0, MAX_ON_RST[15:8], rv[7:0]}, 32'hFFFF);
        wr(REG_MAXON_OFS, {16'h0, MAX_ON_RST});
        wr(4'h2, rv);
        rd_chk(4'h2, 32'h0, 32'hFFFFFFFF);
        wr(REG_STATUS_OFS, rv);
        st(ST_SHUT);
        $display("test registers done");
        cmp_tb.sync_pin <= 1'b1;
        cmp_tb.fb.above70 <= 1'b1;
        cmp_tb.fb.uv90 <= 1'b1;
        cmp_tb.osense.uv90 <= 1'b1;
        cmp_tb.enable <= 1'b1;
        poll(ST_WAIT_RAIL);
        cmp_tb.rail_ok <= 1'b1;
        poll(ST_WAIT_DECAY);
        cmp_tb.out_low_1v25 <= 1'b1;
        poll(ST_SOFT);
        bit_chk(STAT_FPWM_BIT, 1'b0);
        bit_chk(STAT_POK_BIT, 1'b0);
        poll(ST_RUN);
        bit_chk(STAT_FPWM_BIT, 1'b1);
        bit_chk(STAT_POK_BIT, 1'b0);
        cmp_tb.fb.uv90 <= 1'b0;
        settle();
        bit_chk(STAT_POK_BIT, 1'b1);
        $display("test startup and modes done");
        fork
            // 380-cycle period sits over 10 percent faster than internal
            for (int i = 0; i < 20; i++) begin
                repeat (190) @(posedge mclk_i);
                cmp_tb.sync_pin <= ~cmp_tb.sync_pin;
            end
            begin
                repeat (2000) @(posedge mclk_i);
                bit_chk(STAT_SYNC_BIT, 1'b1);
                bit_chk(STAT_FPWM_BIT, 1'b1);
            end
        join
        repeat (2 * int'(PERIOD_RST) + 40) @(posedge mclk_i);
        bit_chk(STAT_SYNC_BIT, 1'b0);
        st(ST_RUN);
        cmp_tb.sync_pin <= 1'b0;
        settle();
        bit_chk(STAT_FPWM_BIT, 1'b0);
        cmp_tb.sync_pin <= 1'b1;
        wr(REG_CTRL_OFS, 32'h1);
        bit_chk(STAT_FPWM_BIT, 1'b0);
        wr(REG_CTRL_OFS, 32'h0);
        bit_chk(STAT_FPWM_BIT, 1'b1);
        $display("test sync done");
        cmp_tb.fb.ov113 <= 1'b1;
        cmp_tb.fb.ov111 <= 1'b1;
        settle();
        bit_chk(STAT_POK_BIT, 1'b0);
        st(ST_RUN);
        cmp_tb.fb.ov113 <= 1'b0;
        cmp_tb.fb.ov111 <= 1'b0;
        settle();
        bit_chk(STAT_POK_BIT, 1'b1);
        cmp_tb.fixed5v <= 1'b1;
        settle();
        bit_chk(STAT_POK_BIT, 1'b0);
        cmp_tb.osense.uv90 <= 1'b0;
        settle();
        bit_chk(STAT_POK_BIT, 1'b1);
        cmp_tb.fixed5v <= 1'b0;
        $display("test levels done");
        trip_len <= 16'hFFFF;
        wr(REG_MAXON_OFS, 32'h0000FFFF);
        repeat (10 * int'(PERIOD_RST)) @(posedge mclk_i);
        bit_chk(STAT_DROP_BIT, 1'b1);
        cnt = 0;
        repeat (int'(PERIOD_RST)) begin
            @(negedge mclk_i);
            if (lo === 1'b1) cnt++;
        end
        // off is confirmed one cycle late, then two sync flops and a flop
        check(32'(REFRESH_CYCLES) - 32'h4, cnt);
        trip_len <= 16'h0064;
        wr(REG_MAXON_OFS, {16'h0, MAX_ON_RST});
        $display("test dropout done");
        cmp_tb.fb.above70 <= 1'b0;
        lim_len <= 16'd50;
        poll(ST_HICCUP);
        poll(ST_SOFT);
        poll(ST_HICCUP);
        lim_len <= 16'hFFFF;
        cmp_tb.fb.above70 <= 1'b1;
        poll(ST_RUN);
        cmp_tb.fb.low20 <= 1'b1;
        poll(ST_HICCUP);
        cmp_tb.fb.low20 <= 1'b0;
        poll(ST_RUN);
        $display("test restart done");
        cmp_tb.over_temp <= 1'b1;
        poll(ST_THERMAL);
        cmp_tb.over_temp <= 1'b0;
        cmp_tb.cooled <= 1'b1;
        cmp_tb.out_low_1v25 <= 1'b0;
        repeat (50) @(posedge mclk_i);
        st(ST_THERMAL);
        cmp_tb.out_low_1v25 <= 1'b1;
        poll(ST_SOFT);
        cmp_tb.cooled <= 1'b0;
        poll(ST_RUN);
        cmp_tb.rail_droop <= 1'b1;
        poll(ST_LDO_OFF);
        cmp_tb.rail_droop <= 1'b0;
        poll(ST_RUN);
        cmp_tb.rail_ok <= 1'b0;
        poll(ST_WAIT_RAIL);
        cmp_tb.rail_ok <= 1'b1;
        poll(ST_RUN);
        cmp_tb.enable <= 1'b0;
        poll(ST_SHUT);
        cmp_tb.out_low_1v25 <= 1'b0;
        cmp_tb.enable <= 1'b1;
        poll(ST_WAIT_DECAY);
        repeat (50) @(posedge mclk_i);
        st(ST_WAIT_DECAY);
        cmp_tb.out_low_1v25 <= 1'b1;
        poll(ST_SOFT);
        $display("test faults done");
        close_out();
    end
endmodule
